// ---- verilog/fhc_pkg.sv ----
package fhc_pkg;
  // ****************************************************************
  // command codes and unlock addresses (byte mode)
  // ****************************************************************
  localparam logic [11:0] FHC_UNLOCK_A1   = 12'haaa;
  localparam logic [11:0] FHC_UNLOCK_A2   = 12'h555;
  localparam logic [7:0]  FHC_D_AA        = 8'haa;
  localparam logic [7:0]  FHC_D_55        = 8'h55;
  localparam logic [7:0]  FHC_C_RESET     = 8'hf0;
  localparam logic [7:0]  FHC_C_AUTOSEL   = 8'h90;
  localparam logic [7:0]  FHC_C_SECURE    = 8'h88;
  localparam logic [7:0]  FHC_C_PROGRAM   = 8'ha0;
  localparam logic [7:0]  FHC_C_BUFLOAD   = 8'h25;
  localparam logic [7:0]  FHC_C_BUFCOMMIT = 8'h29;
  localparam logic [7:0]  FHC_C_ERASE     = 8'h80;
  localparam logic [7:0]  FHC_C_CHIP      = 8'h10;
  localparam logic [7:0]  FHC_C_SECTOR    = 8'h30;
  localparam logic [7:0]  FHC_C_SUSPEND   = 8'hb0;
  localparam logic [7:0]  FHC_C_RESUME    = 8'h30;
  localparam logic [7:0]  FHC_C_EXIT0     = 8'h00;
  localparam logic [7:0]  FHC_C_SET_PPB   = 8'hc0;
  localparam logic [7:0]  FHC_C_SET_DYB   = 8'he0;
  localparam logic [7:0]  FHC_C_SET_PWD   = 8'h60;
  localparam logic [7:0]  FHC_SEL_PROT    = 8'h04;
  localparam logic [7:0]  FHC_SEL_SECPROT = 8'h06;
  localparam int          FHC_MAX_BUF     = 32;
  localparam int          FHC_MAX_BUF_CYC = 37;
  // ****************************************************************
  // operation codes on the user port
  // ****************************************************************
  typedef enum logic [3:0] {
    FHC_OP_READ, FHC_OP_RESET, FHC_OP_PROGRAM, FHC_OP_BUFPROG, FHC_OP_CHIP_ERASE,
    FHC_OP_SECT_ERASE, FHC_OP_SUSPEND, FHC_OP_RESUME, FHC_OP_SEC_ENTER,
    FHC_OP_SEC_EXIT, FHC_OP_PROT_QUERY, FHC_OP_SECPROT_QUERY, FHC_OP_BUF_ABORT,
    FHC_OP_PPB_QUERY, FHC_OP_PPB_ERASE_ALL, FHC_OP_DYB_SET
  } fhc_op_e;
  // ****************************************************************
  // bus timing in clock cycles (10 mhz)
  // ****************************************************************
  localparam int FHC_CLK_NS   = 100;
  localparam int FHC_WE_NS    = 200;
  localparam int FHC_WE_CYC   = (FHC_WE_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
  localparam int FHC_RD_NS    = 200;
  localparam int FHC_RD_CYC   = (FHC_RD_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
endpackage

// ---- verilog/fhc_host.sv ----
`timescale 1ns/1ps
module fhc_host
  import fhc_pkg::*;
#(
  parameter int AW = 22,
  parameter int BUF_MAX = FHC_MAX_BUF
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          cmd_valid,
  input  wire logic [3:0]    cmd_op,
  input  wire logic [AW-1:0] cmd_addr,
  input  wire logic [7:0]    cmd_data,
  input  wire logic [5:0]    cmd_count,
  output logic               cmd_ready,
  output logic               buf_req,
  input  wire logic [AW-1:0] buf_addr,
  input  wire logic [7:0]    buf_data,
  output logic               rsp_valid,
  output logic [7:0]         rsp_data,
  output logic               rsp_protected,
  output logic [AW-1:0]      flash_addr,
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n,
  output logic [7:0]         flash_dq_o,
  output logic               flash_dq_oe,
  input  wire logic [7:0]    flash_dq_i,
  output logic               accelerate_pin
);
  // ****************************************************************
  // sequence table: each bus cycle of the chosen command
  // ****************************************************************
  typedef enum logic [2:0] {FHC_S_IDLE, FHC_S_SETUP, FHC_S_STROBE, FHC_S_HOLD,
                            FHC_S_READ, FHC_S_DONE} fhc_state_e;
  typedef struct packed {
    logic          rd;
    logic [AW-1:0] a;
    logic [7:0]    d;
    logic          last;
  } fhc_cyc_s;

  fhc_state_e    state_reg, state_next;
  fhc_op_e       op_reg, op_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [7:0]    data_reg, data_next;
  logic [5:0]    cnt_reg, cnt_next;
  logic [5:0]    step_reg, step_next;
  logic [2:0]    tmr_reg, tmr_next;
  fhc_cyc_s      cyc;
  logic [AW-1:0] fa_reg, fa_next;
  logic [7:0]    fd_reg, fd_next;
  // strobes are held active low in their flops so the pins see no inverter after the register
  logic          ce_n_reg, ce_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next;
  logic          dqoe_reg, dqoe_next;
  logic          rdy_reg, rdy_next, breq_reg, breq_next, rv_reg, rv_next;
  logic [7:0]    rd_reg, rd_next;
  logic          prot_reg, prot_next, acc_reg, acc_next;

  function automatic fhc_cyc_s w(input logic [AW-1:0] a, input logic [7:0] d,
                                 input logic last);
    w = '{rd: 1'b0, a: a, d: d, last: last};
  endfunction

  function automatic logic [AW-1:0] ua(input logic [11:0] a);
    ua = AW'(a);
  endfunction

  // byte-mode sector select is bits AW-1:15; only the offset is driven below it
  function automatic logic [AW-1:0] sect(input logic [AW-1:0] a, input logic [7:0] o);
    sect = {a[AW-1:15], 7'h00, o};
  endfunction

  always_comb begin
    cyc = w(ua(FHC_UNLOCK_A1), FHC_D_AA, 1'b0);
    if (step_reg == 6'd1) cyc = w(ua(FHC_UNLOCK_A2), FHC_D_55, 1'b0);
    case (op_reg)
      FHC_OP_READ:          cyc = '{rd: 1'b1, a: addr_reg, d: 8'h00, last: 1'b1};
      FHC_OP_RESET:         cyc = w('0, FHC_C_RESET, 1'b1);
      FHC_OP_SUSPEND:       cyc = w('0, FHC_C_SUSPEND, 1'b1);
      FHC_OP_RESUME:        cyc = w('0, FHC_C_RESUME, 1'b1);
      FHC_OP_SEC_ENTER:
        if (step_reg == 6'd2) cyc = w(ua(FHC_UNLOCK_A1), FHC_C_SECURE, 1'b1);
      FHC_OP_SEC_EXIT: begin
        if (step_reg == 6'd2) cyc = w(ua(FHC_UNLOCK_A1), FHC_C_AUTOSEL, 1'b0);
        if (step_reg == 6'd3) cyc = w('0, FHC_C_EXIT0, 1'b1);
      end
      FHC_OP_BUF_ABORT:
        if (step_reg == 6'd2) cyc = w(ua(FHC_UNLOCK_A1), FHC_C_RESET, 1'b1);
      FHC_OP_PROGRAM: begin
        if (step_reg == 6'd2) cyc = w(ua(FHC_UNLOCK_A1), FHC_C_PROGRAM, 1'b0);
        if (step_reg == 6'd3) cyc = w(addr_reg, data_reg, 1'b1);
      end
      FHC_OP_PROT_QUERY, FHC_OP_SECPROT_QUERY: begin
        if (step_reg == 6'd2) cyc = w(ua(FHC_UNLOCK_A1), FHC_C_AUTOSEL, 1'b0);
        if (step_reg == 6'd3)
          cyc = '{rd: 1'b1, last: 1'b0, d: 8'h00,
                  a: (op_reg == FHC_OP_PROT_QUERY) ? sect(addr_reg, FHC_SEL_PROT)
                                                  : AW'(FHC_SEL_SECPROT)};
        if (step_reg == 6'd4) cyc = w('0, FHC_C_RESET, 1'b1);
      end
      FHC_OP_PPB_QUERY, FHC_OP_PPB_ERASE_ALL, FHC_OP_DYB_SET: begin
        // only c0 or e0 is ever chosen: the password set is never entered, so its duties never arise
        if (step_reg == 6'd2)
          cyc = w(ua(FHC_UNLOCK_A1), (op_reg == FHC_OP_DYB_SET) ? FHC_C_SET_DYB
                                                                : FHC_C_SET_PPB, 1'b0);
        if (step_reg == 6'd3)
          cyc = (op_reg == FHC_OP_PPB_QUERY) ?
                '{rd: 1'b1, a: addr_reg, d: 8'h00, last: 1'b0} :
                (op_reg == FHC_OP_DYB_SET) ? w('0, FHC_C_PROGRAM, 1'b0)
                                           : w('0, FHC_C_ERASE, 1'b0);
        if (step_reg == 6'd4)
          cyc = (op_reg == FHC_OP_PPB_QUERY) ? w('0, FHC_C_AUTOSEL, 1'b0) :
                (op_reg == FHC_OP_DYB_SET) ? w(addr_reg, data_reg, 1'b0)
                                           : w('0, FHC_C_SECTOR, 1'b0);
        if (step_reg == 6'd5) cyc = w('0, FHC_C_AUTOSEL, 1'b0);
        if (step_reg == 6'd6 || (op_reg == FHC_OP_PPB_QUERY && step_reg == 6'd5))
          cyc = w('0, FHC_C_EXIT0, 1'b1);
      end
      FHC_OP_CHIP_ERASE, FHC_OP_SECT_ERASE: begin
        if (step_reg == 6'd2) cyc = w(ua(FHC_UNLOCK_A1), FHC_C_ERASE, 1'b0);
        if (step_reg == 6'd4) cyc = w(ua(FHC_UNLOCK_A2), FHC_D_55, 1'b0);
        if (step_reg == 6'd5)
          cyc = (op_reg == FHC_OP_CHIP_ERASE) ? w(ua(FHC_UNLOCK_A1), FHC_C_CHIP, 1'b1)
                                              : w(addr_reg, FHC_C_SECTOR, 1'b1);
      end
      FHC_OP_BUFPROG: begin
        if (step_reg == 6'd2) cyc = w(addr_reg, FHC_C_BUFLOAD, 1'b0);
        if (step_reg == 6'd3) cyc = w(addr_reg, {2'b00, cnt_reg}, 1'b0);
        if (step_reg >= 6'd4) cyc = w(buf_addr, buf_data, 1'b0);
        if (step_reg == 6'd5 + cnt_reg)
          cyc = w(addr_reg, FHC_C_BUFCOMMIT, 1'b1);
      end
      default: cyc = w('0, FHC_C_RESET, 1'b1);
    endcase
  end

  // ****************************************************************
  // bus cycle engine
  // ****************************************************************
  always_comb begin
    state_next = state_reg; op_next = op_reg; addr_next = addr_reg;
    data_next = data_reg; cnt_next = cnt_reg; step_next = step_reg; tmr_next = tmr_reg;
    fa_next = fa_reg; fd_next = fd_reg; ce_n_next = ce_n_reg; we_n_next = we_n_reg;
    oe_n_next = oe_n_reg; dqoe_next = dqoe_reg; rdy_next = 1'b0; breq_next = 1'b0;
    rv_next = 1'b0; rd_next = rd_reg; prot_next = prot_reg; acc_next = acc_reg;
    case (state_reg)
      FHC_S_IDLE: begin
        rdy_next = 1'b1;
        if (cmd_valid && rdy_reg) begin
          op_next = fhc_op_e'(cmd_op); addr_next = cmd_addr; data_next = cmd_data;
          // byte count is capped so the whole sequence stays within the cycle limit
          cnt_next = (cmd_count > 6'(BUF_MAX - 1)) ? 6'(BUF_MAX - 1) : cmd_count;
          step_next = '0; rdy_next = 1'b0; state_next = FHC_S_SETUP;
          acc_next = (fhc_op_e'(cmd_op) == FHC_OP_DYB_SET) ||
                     (fhc_op_e'(cmd_op) == FHC_OP_PPB_ERASE_ALL);
        end
      end
      FHC_S_SETUP: begin
        fa_next = cyc.a; fd_next = cyc.d; ce_n_next = 1'b0;
        dqoe_next = !cyc.rd; oe_n_next = !cyc.rd; tmr_next = '0;
        breq_next = (op_reg == FHC_OP_BUFPROG) && step_reg >= 6'd4 &&
                    step_reg != 6'd5 + cnt_reg;
        state_next = cyc.rd ? FHC_S_READ : FHC_S_STROBE;
      end
      FHC_S_STROBE: begin
        we_n_next = 1'b0; tmr_next = tmr_reg + 3'd1;
        if (tmr_reg == 3'(FHC_WE_CYC - 1)) state_next = FHC_S_HOLD;
      end
      FHC_S_READ: begin
        tmr_next = tmr_reg + 3'd1;
        if (tmr_reg == 3'(FHC_RD_CYC)) begin
          rd_next = flash_dq_i; prot_next = !flash_dq_i[0];
          state_next = FHC_S_HOLD;
        end
      end
      FHC_S_HOLD: begin
        we_n_next = 1'b1; oe_n_next = 1'b1; ce_n_next = 1'b1; dqoe_next = 1'b0;
        step_next = step_reg + 6'd1;
        state_next = cyc.last ? FHC_S_DONE : FHC_S_SETUP;
      end
      FHC_S_DONE: begin
        rv_next = 1'b1; acc_next = 1'b0; state_next = FHC_S_IDLE;
      end
      default: state_next = FHC_S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= FHC_S_IDLE; op_reg <= FHC_OP_READ; addr_reg <= '0; data_reg <= '0;
      cnt_reg <= '0; step_reg <= '0; tmr_reg <= '0; fa_reg <= '0; fd_reg <= '0;
      ce_n_reg <= 1'b1; we_n_reg <= 1'b1; oe_n_reg <= 1'b1; dqoe_reg <= 1'b0;
      rdy_reg <= 1'b0; breq_reg <= 1'b0; rv_reg <= 1'b0; rd_reg <= '0;
      prot_reg <= 1'b0; acc_reg <= 1'b0;
    end else begin
      state_reg <= state_next; op_reg <= op_next; addr_reg <= addr_next;
      data_reg <= data_next; cnt_reg <= cnt_next; step_reg <= step_next;
      tmr_reg <= tmr_next; fa_reg <= fa_next; fd_reg <= fd_next; ce_n_reg <= ce_n_next;
      we_n_reg <= we_n_next; oe_n_reg <= oe_n_next; dqoe_reg <= dqoe_next;
      rdy_reg <= rdy_next;
      breq_reg <= breq_next; rv_reg <= rv_next; rd_reg <= rd_next;
      prot_reg <= prot_next; acc_reg <= acc_next;
    end
  end

  assign cmd_ready = rdy_reg;
  assign buf_req = breq_reg;
  assign rsp_valid = rv_reg;
  assign rsp_data = rd_reg;
  assign rsp_protected = prot_reg;
  assign flash_addr = fa_reg;
  assign flash_ce_n = ce_n_reg;
  assign flash_we_n = we_n_reg;
  assign flash_oe_n = oe_n_reg;
  assign flash_dq_o = fd_reg;
  assign flash_dq_oe = dqoe_reg;
  assign accelerate_pin = acc_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_strobe;
    !flash_we_n [*2];
  endsequence
  property p_we_width;
    @(posedge clk) disable iff (sys_rst) $fell(flash_we_n) |-> s_strobe ##1 flash_we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
  property p_ce_under_we;
    @(posedge clk) disable iff (sys_rst) !flash_we_n |-> !flash_ce_n && flash_dq_oe;
  endproperty
  a_ce_under_we: assert property (p_ce_under_we) else $error("we without ce");
  property p_no_contend;
    @(posedge clk) disable iff (sys_rst) !(flash_dq_oe && !flash_oe_n);
  endproperty
  a_no_contend: assert property (p_no_contend) else $error("bus contention");
  property p_acc;
    @(posedge clk) disable iff (sys_rst)
      (!flash_we_n && (op_reg == FHC_OP_DYB_SET)) |-> accelerate_pin;
  endproperty
  a_acc: assert property (p_acc) else $error("accelerate pin low");
  property p_prot;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == FHC_S_READ && tmr_reg == 3'(FHC_RD_CYC))
      |=> rsp_protected == !$past(flash_dq_i[0]) && rsp_data == $past(flash_dq_i);
  endproperty
  a_prot: assert property (p_prot) else $error("protect flag mismatch");
  property p_step_cap;
    @(posedge clk) disable iff (sys_rst) step_reg <= 6'(FHC_MAX_BUF_CYC);
  endproperty
  a_step_cap: assert property (p_step_cap) else $error("too many cycles");
  property p_resp;
    @(posedge clk) disable iff (sys_rst) (state_reg == FHC_S_DONE) |=> rsp_valid ##1 cmd_ready;
  endproperty
  a_resp: assert property (p_resp) else $error("response timing");
  property p_first_unlock;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == FHC_S_SETUP && step_reg == 6'd0 && op_reg == FHC_OP_SEC_ENTER)
      |=> flash_addr == ua(FHC_UNLOCK_A1) && flash_dq_o == FHC_D_AA;
  endproperty
  a_first_unlock: assert property (p_first_unlock) else $error("bad unlock");
endmodule

// ---- tb/fhc_flash_model.sv ----
`timescale 1ns/1ps
module fhc_flash_model
  import fhc_pkg::*;
#(
  parameter int         AW     = 22,
  parameter int         RD_DLY = 150,
  parameter logic [7:0] SECF   = 8'h80
) (
  input  wire logic          flash_ce_n,
  input  wire logic          flash_we_n,
  input  wire logic          flash_oe_n,
  input  wire logic [AW-1:0] flash_addr,
  input  wire logic [7:0]    flash_dq_o,
  input  wire logic          accelerate_pin,
  output logic [7:0]         flash_dq_i
);
  // ****
  // write capture and command decode
  // ****
  logic [AW+8:0] q[$];
  logic [AW-1:0] a_lat;
  logic [7:0]    d1;
  logic [7:0]    d2;
  logic [1:0]    mode;
  logic          a_ok;
  wire           stb = flash_we_n | flash_ce_n;
  initial begin
    a_ok = 1'b0;
    mode = 2'h0;
    d1 = 8'h00;
    d2 = 8'h00;
    flash_dq_i = 8'h00;
  end
  always @(negedge stb) begin
    a_lat = flash_addr;
    a_ok = 1'b1;
  end
  always @(posedge stb) begin
    if (a_ok) begin
      q.push_back({accelerate_pin, a_lat, flash_dq_o});
      if (flash_dq_o == FHC_C_RESET) mode = 2'h0;
      else if (d1 == 8'h90 && flash_dq_o == FHC_C_EXIT0) mode = 2'h0;
      else if (d2 == FHC_D_AA && d1 == FHC_D_55 && a_lat[11:0] == FHC_UNLOCK_A1) begin
        if (flash_dq_o == FHC_C_AUTOSEL) mode = 2'h1;
        if (flash_dq_o == FHC_C_SET_PPB) mode = 2'h2;
        if (flash_dq_o == FHC_C_SET_PWD) mode = 2'h3;
      end
      d2 = d1;
      d1 = flash_dq_o;
    end
    a_ok = 1'b0;
  end
  // ****
  // read side: deselected data lines toggle so a stale byte never reads as good
  // ****
  function automatic logic [7:0] rd(input logic [AW-1:0] a);
    if (mode == 2'h1 && a[7:0] == FHC_SEL_PROT) return {7'h00, a[15]};
    if (mode == 2'h1 && a[7:0] == FHC_SEL_SECPROT) return SECF;
    if (mode == 2'h2) return {7'h00, !a[15]};
    if (mode == 2'h3) return {6'h00, a[1:0]};
    return a[7:0] ^ 8'h5a;
  endfunction
  always @(flash_oe_n or flash_ce_n or flash_addr) begin
    if (!flash_oe_n && !flash_ce_n) flash_dq_i <= #RD_DLY rd(flash_addr);
    else flash_dq_i <= ~flash_dq_i;
  end
endmodule

// ---- tb/flash_command_decoder_byte_mode_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  tests_run++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
  end \
end
module flash_command_decoder_byte_mode_test
  import fhc_pkg::*;
;
  localparam logic [21:0] A1   = {10'h000, FHC_UNLOCK_A1};
  localparam logic [21:0] A2   = {10'h000, FHC_UNLOCK_A2};
  localparam logic [21:0] BPG  = 22'h020040;
  localparam logic [7:0]  SECF = 8'h80;
  logic clk, sys_rst, cmd_valid, cmd_ready, buf_req, rsp_valid, rsp_protected;
  logic flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, accelerate_pin;
  logic [3:0]  cmd_op;
  logic [21:0] cmd_addr, buf_addr, flash_addr;
  logic [7:0]  cmd_data, buf_data, rsp_data, flash_dq_o, flash_dq_i;
  logic [5:0]  cmd_count, bk;
  logic [21:0] xa[$];
  logic [7:0]  xd[$];
  logic [1:0]  xm[$];
  int          error_cnt, tests_run, cyc;
  fhc_host uut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_count(cmd_count), .cmd_ready(cmd_ready),
    .buf_req(buf_req), .buf_addr(buf_addr), .buf_data(buf_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_protected(rsp_protected), .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i),
    .accelerate_pin(accelerate_pin));
  fhc_flash_model #(.SECF(SECF)) mdl (.flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
    .accelerate_pin(accelerate_pin), .flash_dq_i(flash_dq_i));
  // ****
  // buffer pairs stay inside one 32-byte page
  // ****
  assign buf_addr = BPG + {16'h0000, bk};
  assign buf_data = {2'b00, bk} ^ 8'hc3;
  always @(negedge clk) if (buf_req === 1'b1) bk <= bk + 6'h01;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      conclude();
    end
  end
  // ****
  // shared bus tasks
  // ****
  task automatic w(input logic [21:0] a, input logic [7:0] d, input logic [1:0] m);
    xa.push_back(a);
    xd.push_back(d);
    xm.push_back(m);
  endtask
  task automatic u();
    w(A1, FHC_D_AA, 2'h1);
    w(A2, FHC_D_55, 2'h1);
  endtask
  task automatic run(input fhc_op_e op, input logic [21:0] a, input logic [7:0] d,
                     input logic [5:0] c);
    int n;
    mdl.q.delete();
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_count = c;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("response", 1'b1, rsp_valid)
  endtask
  task automatic cmpw();
    `CHK("write count", xa.size(), mdl.q.size())
    for (int i = 0; i < xa.size() && i < mdl.q.size(); i++) begin
      if (xm[i][0]) `CHK("write addr", xa[i], mdl.q[i][29:8])
      `CHK("write data", xd[i], mdl.q[i][7:0])
      if (xm[i][1]) `CHK("accelerate", 1'b1, mdl.q[i][30])
    end
    xa.delete();
    xd.delete();
    xm.delete();
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_read();
    run(FHC_OP_READ, 22'h012345, 8'h00, 6'h00);
    `CHK("array byte", 8'h45 ^ 8'h5a, rsp_data)
    cmpw();
  endtask
  task automatic t_program();
    u();
    w(A1, FHC_C_PROGRAM, 2'h1);
    w(22'h03c7f1, 8'h96, 2'h1);
    run(FHC_OP_PROGRAM, 22'h03c7f1, 8'h96, 6'h00);
    cmpw();
  endtask
  task automatic t_erase();
    for (int s = 0; s < 2; s++) begin
      u();
      w(A1, FHC_C_ERASE, 2'h1);
      u();
      w(s ? 22'h1f8000 : A1, s ? FHC_C_SECTOR : FHC_C_CHIP, 2'h1);
      run(s ? FHC_OP_SECT_ERASE : FHC_OP_CHIP_ERASE, 22'h1f8000, 8'h00, 6'h00);
      cmpw();
    end
  endtask
  task automatic t_secure();
    u();
    w(A1, FHC_C_SECURE, 2'h1);
    run(FHC_OP_SEC_ENTER, 22'h0, 8'h00, 6'h00);
    cmpw();
    u();
    w(A1, FHC_C_AUTOSEL, 2'h1);
    w(A1, FHC_C_EXIT0, 2'h0);
    run(FHC_OP_SEC_EXIT, 22'h0, 8'h00, 6'h00);
    cmpw();
  endtask
  task automatic t_susp();
    w(A1, FHC_C_SUSPEND, 2'h0);
    run(FHC_OP_SUSPEND, 22'h0, 8'h00, 6'h00);
    cmpw();
    w(A1, FHC_C_RESUME, 2'h0);
    run(FHC_OP_RESUME, 22'h0, 8'h00, 6'h00);
    cmpw();
  endtask
  task automatic t_buf();
    bk = 6'h00;
    u();
    w(BPG, FHC_C_BUFLOAD, 2'h1);
    w(BPG, 8'h1f, 2'h1);
    for (int k = 0; k < 32; k++) w(BPG + 22'(k), 8'(k) ^ 8'hc3, 2'h1);
    w(BPG, FHC_C_BUFCOMMIT, 2'h1);
    run(FHC_OP_BUFPROG, BPG, 8'h00, 6'h1f);
    cmpw();
    `CHK("buffer pairs", 6'h20, bk)
    u();
    w(A1, FHC_C_RESET, 2'h1);
    run(FHC_OP_BUF_ABORT, 22'h0, 8'h00, 6'h00);
    cmpw();
  endtask
  task automatic t_query();
    logic [21:0] sa;
    for (int p = 0; p < 2; p++) begin
      sa = p ? 22'h018000 : 22'h010000;
      u();
      w(A1, FHC_C_AUTOSEL, 2'h1);
      w(A1, FHC_C_RESET, 2'h0);
      run(FHC_OP_PROT_QUERY, sa, 8'h00, 6'h00);
      `CHK("sector status", {7'h00, p[0]}, rsp_data)
      cmpw();
      u();
      w(A1, FHC_C_SET_PPB, 2'h1);
      w(A1, 8'h90, 2'h0);
      w(A1, FHC_C_EXIT0, 2'h0);
      run(FHC_OP_PPB_QUERY, sa, 8'h00, 6'h00);
      `CHK("persistent status", p[0], rsp_protected)
      cmpw();
    end
    u();
    w(A1, FHC_C_AUTOSEL, 2'h1);
    w(A1, FHC_C_RESET, 2'h0);
    run(FHC_OP_SECPROT_QUERY, 22'h0, 8'h00, 6'h00);
    `CHK("secured status", SECF, rsp_data)
    cmpw();
  endtask
  task automatic t_prot();
    u();
    w(A1, FHC_C_SET_PPB, 2'h1);
    w(A1, FHC_C_ERASE, 2'h0);
    w(A1, FHC_C_SECTOR, 2'h2);
    w(A1, 8'h90, 2'h0);
    w(A1, FHC_C_EXIT0, 2'h0);
    run(FHC_OP_PPB_ERASE_ALL, 22'h0, 8'h00, 6'h00);
    cmpw();
    u();
    w(A1, FHC_C_SET_DYB, 2'h1);
    w(A1, FHC_C_PROGRAM, 2'h0);
    w(22'h0a8000, 8'h00, 2'h3);
    w(A1, 8'h90, 2'h0);
    w(A1, FHC_C_EXIT0, 2'h0);
    run(FHC_OP_DYB_SET, 22'h0a8000, 8'h00, 6'h00);
    cmpw();
    `CHK("accelerate idle", 1'b0, accelerate_pin)
  endtask
  initial begin
    {sys_rst, cmd_valid, cmd_op, cmd_addr, cmd_data, cmd_count, bk} = '0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_read();
    t_program();
    t_erase();
    t_secure();
    t_susp();
    t_buf();
    t_query();
    t_prot();
    conclude();
  end
endmodule
